// file: rtl/bc_priority_consts.vh
// Constants for the block control priority network and clock service.
`ifndef BC_PRIORITY_CONSTS_VH
`define BC_PRIORITY_CONSTS_VH
`define RF_DEPTH 64
`define RF_ADDR_W 6
`define RF_DATA_W 24
`define RF_CLOCK_WORD 6'h12
`define RF_MASK_WORD 6'h1A
`define RF_TYPE_LAST_WORD 6'h1B
`define CLOCK_HZ 20000000
`define RF_CYCLE_NS 500
`define CLK_PERIOD_NS 50
`define RF_CYCLES 4'hA
`define GRP_THIRD 2'h2
`define GRP_SECOND 2'h1
`define GRP_FIRST 2'h0
`endif

// file: rtl/reg_file.v
// Sixty-four word register file with a fixed access time.
`include "bc_priority_consts.vh"
module reg_file
(
	// Clock and reset.
	input wire i_clock,
	input wire i_rst_n,
	// Access port.
	input wire i_req,
	input wire i_we,
	input wire [`RF_ADDR_W-1:0] i_addr,
	input wire [`RF_DATA_W-1:0] i_wdata,
	output reg [`RF_DATA_W-1:0] o_rdata,
	output reg o_done
);
	reg [`RF_DATA_W-1:0] mem [0:`RF_DEPTH-1];
	reg [3:0] cnt_q;
	reg busy_q;
	always @(posedge i_clock)
	begin
		if (i_req && !busy_q && !o_done && i_we)
			mem[i_addr] <= i_wdata;
	end
	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 24'h000000;
		end
		else
		begin
			o_done <= 1'b0;
			// A request still held in the cycle that done shows is not taken again.
			if (i_req && !busy_q && !o_done)
			begin
				busy_q <= 1'b1;
				cnt_q <= 4'h1;
				o_rdata <= mem[i_addr];
			end
			else if (busy_q)
			begin
				if (cnt_q == `RF_CYCLES)
				begin
					busy_q <= 1'b0;
					o_done <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule

// file: rtl/block_control_priority_rtc.v
// Block control priority arbiter with the real-time clock service.
`include "bc_priority_consts.vh"
// Overview of operation
// - Any group request beats program; program granted only when no group pends.
// - Group scanner rotates third, second, first, third after each service.
// - Each group scans four members top down, restarting at top after service.
// - Groups: channels 0-3, channels 4-7, clock/typewriter/display/search-move.
// - Clock is 24-bit, adds one per millisecond, wraps to zero.
// - Paced by 1 kHz tick; runs from power-up without software.
// - Each tick read word 22, increment, write back, compare with word 32.
// - Updated value equal to mask sets clock interrupt.
// - Master clear leaves the stored clock count alone.
// - Register file is 64 words of 24 bits, half microsecond cycle.
// - Word 32 is the clock compare mask.
module block_control_priority_rtc
(
	// Clock and reset.
	input wire i_clock,
	input wire i_rst_n,
	input wire i_master_clear,
	// Pin inputs.
	input wire i_tick_1khz,
	// Requests and completions.
	input wire i_prog_req,
	input wire [7:0] i_chan_req,
	input wire i_type_req,
	input wire i_disp_req,
	input wire i_srch_req,
	input wire i_done,
	// Register file access from other requesters and software.
	input wire i_sw_we,
	input wire [`RF_ADDR_W-1:0] i_sw_addr,
	input wire [`RF_DATA_W-1:0] i_sw_wdata,
	// Grants and status.
	output reg o_prog_grant,
	output reg [7:0] o_chan_grant,
	output reg o_type_grant,
	output reg o_disp_grant,
	output reg o_srch_grant,
	output reg o_clock_irq,
	output reg [`RF_DATA_W-1:0] o_rdata,
	output reg o_sw_done
);
	localparam S_IDLE = 3'h0;
	localparam S_GRANT = 3'h1;
	localparam S_RD = 3'h2;
	localparam S_WR = 3'h3;
	localparam S_SW = 3'h4;
	reg [2:0] state_q;
	reg tick_s1_q;
	reg tick_s2_q;
	reg tick_s3_q;
	reg clk_pend_q;
	reg [1:0] grp_q;
	reg [1:0] sel_grp_q;
	reg [`RF_DATA_W-1:0] cmp_q;
	reg sel_prog_q;
	reg [`RF_DATA_W-1:0] time_q;
	reg rf_req;
	reg rf_we;
	reg [`RF_ADDR_W-1:0] rf_addr;
	reg [`RF_DATA_W-1:0] rf_wdata;
	wire [`RF_DATA_W-1:0] rf_rdata;
	wire rf_done;
	wire [3:0] g_req [0:2];
	wire [2:0] g_any;
	wire [1:0] g_pos [0:2];
	wire tick_rise;
	reg [1:0] pick_grp;
	reg found;
	reg [1:0] tmp;
	integer k;

	assign tick_rise = tick_s2_q && !tick_s3_q;
	assign g_req[0] = {i_chan_req[3], i_chan_req[2], i_chan_req[1], i_chan_req[0]};
	assign g_req[1] = {i_chan_req[7], i_chan_req[6], i_chan_req[5], i_chan_req[4]};
	assign g_req[2] = {i_srch_req, i_disp_req, i_type_req, clk_pend_q};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : grp
			assign g_any[g] = |g_req[g];
			assign g_pos[g] = g_req[g][0] ? 2'h0 : g_req[g][1] ? 2'h1 : g_req[g][2] ? 2'h2 : 2'h3;
		end
	endgenerate

	always @*
	begin
		pick_grp = grp_q;
		found = 1'b0;
		tmp = grp_q;
		for (k = 0; k < 3; k = k + 1)
		begin
			if (!found && g_any[tmp])
			begin
				pick_grp = tmp;
				found = 1'b1;
			end
			tmp = (tmp == `GRP_FIRST) ? `GRP_THIRD : tmp - 2'h1;
		end
	end

	always @*
	begin
		rf_req = 1'b0;
		rf_we = 1'b0;
		rf_addr = `RF_CLOCK_WORD;
		rf_wdata = time_q;
		case (state_q)
			S_RD: rf_req = 1'b1;
			S_WR:
			begin
				rf_req = 1'b1;
				rf_we = 1'b1;
			end
			S_SW:
			begin
				rf_req = 1'b1;
				rf_we = i_sw_we;
				rf_addr = i_sw_addr;
				rf_wdata = i_sw_wdata;
			end
			default: rf_req = 1'b0;
		endcase
	end

	reg_file u_rf
	(
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_req(rf_req),
		.i_we(rf_we),
		.i_addr(rf_addr),
		.i_wdata(rf_wdata),
		.o_rdata(rf_rdata),
		.o_done(rf_done)
	);

	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= S_IDLE;
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_s3_q <= 1'b0;
			clk_pend_q <= 1'b0;
			grp_q <= `GRP_THIRD;
			sel_grp_q <= 2'h0;
			sel_prog_q <= 1'b0;
			time_q <= 24'h000000;
			o_prog_grant <= 1'b0;
			o_chan_grant <= 8'h00;
			o_type_grant <= 1'b0;
			o_disp_grant <= 1'b0;
			o_srch_grant <= 1'b0;
			o_clock_irq <= 1'b0;
			o_rdata <= 24'h000000;
			o_sw_done <= 1'b0;
		end
		else
		begin
			tick_s1_q <= i_tick_1khz;
			tick_s2_q <= tick_s1_q;
			tick_s3_q <= tick_s2_q;
			o_sw_done <= 1'b0;
			if (i_master_clear)
				o_clock_irq <= 1'b0;
			if (tick_rise)
				clk_pend_q <= 1'b1;
			case (state_q)
				S_IDLE:
				begin
					if (|g_any)
					begin
						sel_prog_q <= 1'b0;
						sel_grp_q <= pick_grp;
						if (pick_grp == `GRP_THIRD && g_pos[2] == 2'h0)
							state_q <= S_RD;
						else if (pick_grp == `GRP_THIRD && g_pos[2] == 2'h3)
							state_q <= S_SW;
						else
						begin
							state_q <= S_GRANT;
							if (pick_grp == `GRP_THIRD)
							begin
								o_type_grant <= g_pos[2] == 2'h1;
								o_disp_grant <= g_pos[2] == 2'h2;
							end
							else
								o_chan_grant <= 8'h01 << {pick_grp[0], g_pos[pick_grp]};
						end
					end
					else if (i_prog_req)
					begin
						sel_prog_q <= 1'b1;
						state_q <= S_SW;
					end
				end
				S_GRANT:
				begin
					if (i_done)
					begin
						o_chan_grant <= 8'h00;
						o_type_grant <= 1'b0;
						o_disp_grant <= 1'b0;
						grp_q <= (sel_grp_q == `GRP_FIRST) ? `GRP_THIRD : sel_grp_q - 2'h1;
						state_q <= S_IDLE;
					end
				end
				S_SW:
				begin
					o_prog_grant <= sel_prog_q;
					o_srch_grant <= !sel_prog_q;
					if (rf_done)
					begin
						o_rdata <= rf_rdata;
						o_sw_done <= 1'b1;
						o_prog_grant <= 1'b0;
						o_srch_grant <= 1'b0;
						if (!sel_prog_q)
							grp_q <= `GRP_SECOND;
						state_q <= S_IDLE;
					end
				end
				S_RD:
				begin
					if (rf_done)
					begin
						time_q <= rf_rdata + 24'h000001;
						state_q <= S_WR;
					end
				end
				S_WR:
				begin
					if (rf_done)
					begin
						if (!tick_rise)
							clk_pend_q <= 1'b0;
						grp_q <= `GRP_SECOND;
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
			if (state_q == S_WR && rf_done && time_q == cmp_q)
				o_clock_irq <= 1'b1;
		end
	end

	// Mask word shadow captured on write.
	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cmp_q <= 24'h000000;
		else if (state_q == S_SW && rf_done && i_sw_we && i_sw_addr == `RF_MASK_WORD)
			cmp_q <= i_sw_wdata;
	end
endmodule

// file: bench/bc_prio_chk.sv
// Port checker for the block control priority arbiter.
module bc_prio_chk
(
	// Clock and reset.
	input logic i_clock,
	input logic i_rst_n,
	// Inputs.
	input logic i_master_clear,
	input logic [7:0] i_chan_req,
	input logic i_done,
	// Outputs.
	input logic o_prog_grant,
	input logic [7:0] o_chan_grant,
	input logic o_type_grant,
	input logic o_disp_grant,
	input logic o_srch_grant,
	input logic o_clock_irq,
	input logic o_sw_done
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	wire [11:0] g = {o_prog_grant, o_srch_grant, o_disp_grant, o_type_grant, o_chan_grant};
	wire c = |o_chan_grant;
	property p_one;
		$onehot0(g);
	endproperty
	a_one: assert property (p_one) else $error("Two grants.");
	property p_hold;
		c && !i_done |=> $stable(o_chan_grant);
	endproperty
	a_hold: assert property (p_hold) else $error("Grant moved.");
	property p_free;
		c && i_done |=> !c;
	endproperty
	a_free: assert property (p_free) else $error("Grant kept.");
	property p_grp;
		$rose(o_prog_grant) |-> $past(i_chan_req, 2) == 8'h00;
	endproperty
	a_grp: assert property (p_grp) else $error("Program beat group.");
	property p_src;
		$rose(c) |-> (o_chan_grant & $past(i_chan_req)) != 8'h00;
	endproperty
	a_src: assert property (p_src) else $error("Unrequested grant.");
	property p_wait;
		|i_chan_req |-> ##[0:300] c;
	endproperty
	a_wait: assert property (p_wait) else $error("Channel starved.");
	property p_pulse;
		o_sw_done |=> !o_sw_done;
	endproperty
	a_pulse: assert property (p_pulse) else $error("Long done.");
	property p_mc;
		i_master_clear |=> !o_clock_irq;
	endproperty
	a_mc: assert property (p_mc) else $error("Irq kept.");
	c_prog: cover property ($rose(o_prog_grant));
	c_irq: cover property ($rose(o_clock_irq));
	c_last: cover property (o_chan_grant[7]);
endmodule
bind block_control_priority_rtc bc_prio_chk i_bc_prio_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_master_clear(i_master_clear), .i_chan_req(i_chan_req), .i_done(i_done), .o_prog_grant(o_prog_grant),
	.o_chan_grant(o_chan_grant), .o_type_grant(o_type_grant), .o_disp_grant(o_disp_grant),
	.o_srch_grant(o_srch_grant), .o_clock_irq(o_clock_irq), .o_sw_done(o_sw_done));

// file: bench/bc_partner.sv
// Controllers that end a held grant promptly or slowly.
module bc_partner
(
	// Clock and pacing.
	input logic i_clock,
	input logic i_slow,
	// Grants.
	input logic [7:0] i_chan_grant,
	input logic i_type_grant,
	input logic i_disp_grant,
	// Completion.
	output logic o_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q = 4'h0;
	wire held = (|i_chan_grant) | i_type_grant | i_disp_grant;
	initial o_done = 1'b0;
	always @(negedge i_clock)
	begin
		o_done <= held && cnt_q == (i_slow ? 4'h5 : 4'h0);
		cnt_q <= held ? cnt_q + 4'h1 : 4'h0;
	end
endmodule

// file: bench/tb.sv
// Bench for the block control priority arbiter.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic mc = 1'b0;
	logic tick = 1'b0;
	logic slow = 1'b0;
	logic we = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [23:0] wdata = 24'h000000;
	logic [11:0] rq = 12'h000;
	logic [7:0] cg;
	logic pg, tg, dg, sg, irq, swd, done;
	logic [23:0] rd, got;
	wire [11:0] g = {pg, sg, dg, tg, cg};
	logic [23:0] rows [11] = '{24'hBFF100, 24'h000010, 24'h000001, 24'h000200, 24'h000020, 24'h000002,
		24'h000040, 24'h000004, 24'h000080, 24'h000008, 24'h000800};
	int fail_count = 0;
	int total_checks = 0;
	int k;
	always #25 i_clock = ~i_clock;
	block_control_priority_rtc i_block_control_priority_rtc (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_master_clear(mc), .i_tick_1khz(tick), .i_prog_req(rq[11]), .i_chan_req(rq[7:0]), .i_type_req(rq[8]),
		.i_disp_req(rq[9]), .i_srch_req(rq[10]), .i_done(done), .i_sw_we(we), .i_sw_addr(addr),
		.i_sw_wdata(wdata), .o_prog_grant(pg), .o_chan_grant(cg), .o_type_grant(tg), .o_disp_grant(dg),
		.o_srch_grant(sg), .o_clock_irq(irq), .o_rdata(rd), .o_sw_done(swd));
	bc_partner i_bc_partner (.i_clock(i_clock), .i_slow(slow), .i_chan_grant(cg), .i_type_grant(tg),
		.i_disp_grant(dg), .o_done(done));
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		total_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict;
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic do_reset;
		@(negedge i_clock);
		i_rst_n = 1'b0;
		repeat (10) @(negedge i_clock);
		chk("reset outputs", 24'h000000, {10'h000, g, irq, swd});
		i_rst_n = 1'b1;
	endtask
	task automatic wait_g(input logic want);
		for (k = 0; k < 300 && (g != 12'h000) !== want; k++)
			@(posedge i_clock) #1;
	endtask
	task automatic wait_sw(input int b);
		for (k = 0; k < 100 && swd !== 1'b1; k++)
			@(posedge i_clock) #1;
		got = rd;
		chk("file done", 24'h000001, {23'h000000, swd});
		@(negedge i_clock);
		rq[b] = 1'b0;
	endtask
	task automatic acc(input int b, input logic w, input logic [5:0] a, input logic [23:0] d);
		@(negedge i_clock);
		we = w;
		addr = a;
		wdata = d;
		rq[b] = 1'b1;
		wait_g(1'b1);
		chk("access grant", {12'h000, 12'h001 << b}, {12'h000, g});
		wait_sw(b);
	endtask
	task automatic pulse_tick;
		@(negedge i_clock);
		tick = 1'b1;
		repeat (5) @(negedge i_clock);
		tick = 1'b0;
		repeat (60) @(negedge i_clock);
	endtask
	initial
	begin
		#2000000;
		fail_count++;
		give_verdict();
	end
	initial
	begin
		do_reset();
		foreach (rows[i])
		begin
			@(negedge i_clock);
			rq = rq | rows[i][23:12];
			slow = i[0];
			wait_g(1'b1);
			chk("grant", {12'h000, rows[i][11:0]}, {12'h000, g});
			@(negedge i_clock);
			if (g[11])
				wait_sw(11);
			rq = rq & ~(g & 12'h3FF);
			wait_g(1'b0);
		end
		acc(11, 1'b1, 6'h3F, 24'hA5A5A5);
		acc(10, 1'b0, 6'h3F, 24'h000000);
		chk("top word", 24'hA5A5A5, got);
		acc(11, 1'b1, 6'h12, 24'hFFFFFF);
		acc(10, 1'b1, 6'h1A, 24'h000001);
		acc(10, 1'b1, 6'h1B, 24'h000100);
		pulse_tick();
		chk("irq", 24'h000000, {23'h000000, irq});
		acc(11, 1'b0, 6'h12, 24'h000000);
		chk("clock wrap", 24'h000000, got);
		pulse_tick();
		chk("irq", 24'h000001, {23'h000000, irq});
		@(negedge i_clock);
		mc = 1'b1;
		@(negedge i_clock);
		mc = 1'b0;
		chk("irq", 24'h000000, {23'h000000, irq});
		acc(11, 1'b0, 6'h12, 24'h000000);
		chk("clock", 24'h000001, got);
		@(negedge i_clock);
		rq[0] = 1'b1;
		slow = 1'b1;
		pulse_tick();
		rq[0] = 1'b0;
		wait_g(1'b0);
		acc(10, 1'b0, 6'h12, 24'h000000);
		chk("clock", 24'h000002, got);
		do_reset();
		acc(11, 1'b0, 6'h12, 24'h000000);
		chk("clock", 24'h000002, got);
		give_verdict();
	end
endmodule
